// >>> dv/ffc_flash_model.sv
// Behavioural byte-wide flash that answers the host's pin cycles.
`timescale 1ns/100ps
module ffc_flash_model #(
	parameter int BUSY = 6,
	parameter int WIN = 2
) (
	// Bus and strobes from the host.
	input wire logic [16:0] addr_in,
	input wire logic [7:0] data_in,
	input wire logic data_oe_n_in,
	input wire logic ce_n_in,
	input wire logic we_n_in,
	input wire logic oe_n_in,
	// Answer and protocol faults.
	output logic [7:0] q_out,
	output int err_out
);
	logic [7:0] mem [logic [16:0]];
	logic [7:0] wd;
	logic [7:0] last;
	logic [16:0] lat_a;
	logic tog;
	int step;
	int left;
	int mode;
	wire rd_en = !ce_n_in && !oe_n_in;
	function automatic logic [7:0] rdm(input logic [16:0] a);
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction
	task automatic take(input logic [16:0] a, input logic [7:0] d);
		if (mode == 3) begin
			if (d == 8'hF0) mode = 0;
		end else if (mode == 2 && d == 8'hB0) begin
			mode = 4;
		end else if (mode == 4 && d == 8'h30) begin
			mode = 2;
		end else if (mode == 0) begin
			case (step)
				0, 3: step = (a == 17'h05555 && d == 8'hAA) ? step + 1 : 0;
				1, 4: step = (a == 17'h02AAA && d == 8'h55) ? step + 1 : 0;
				2: step = (d == 8'hA0) ? 6 : (d == 8'h80) ? 3 : 0;
				6: begin
					wd = d;
					step = 0;
					mode = ((rdm(a) & d) == d) ? 1 : 3;
					if (mode == 1) mem[a] = d;
					left = (mode == 1) ? BUSY : 4 * BUSY;
				end
				default: begin
					if (d == 8'h10) mem.delete();
					if (d == 8'h30) foreach (mem[k]) if (k[16:13] == a[16:13]) mem[k] = 8'hFF;
					mode = (d == 8'h10 || d == 8'h30) ? 2 : 0;
					left = BUSY + WIN;
					step = 0;
				end
			endcase
		end
	endtask
	initial begin
		step = 0;
		mode = 0;
		err_out = 0;
		tog = 1'b0;
		last = 8'h00;
		q_out = 8'hFF;
	end
	always @(negedge we_n_in) lat_a = addr_in;
	always @(posedge we_n_in) begin
		if (!ce_n_in && oe_n_in && !data_oe_n_in) take(lat_a, data_in);
		else if (!ce_n_in) err_out++;
	end
	always @(posedge rd_en) begin
		// The address moves in the same step as the strobes, so look at it a little later.
		#1;
		if (mode != 0 && mode != 4) begin
			tog = !tog;
			if (left > 0) left--;
			if (mode == 3) last = {~wd[7], tog, left == 0, 5'h00};
			else if (mode == 1) last = {~wd[7], tog, 6'h00};
			else last = {1'b0, tog, 2'h0, left < BUSY, 3'h0};
			if (mode != 3 && left == 0) mode = 0;
		end
		if (mode == 0 || mode == 4) last = rdm(addr_in);
		q_out = last;
	end
	// A released bus shows the inverse of the last byte, so a stale value never passes.
	always @(negedge rd_en) q_out = ~last;
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the flash command host against the flash model.
`timescale 1ns/100ps
`include "ffc_map.svh"
module testbench;
	logic clk, rstn, psel, pen, pwr, e, foe_n, ce_n, we_n, oe_n;
	logic [11:0] pad;
	logic [31:0] pwd, prd, st, r;
	logic pready, perr;
	logic [16:0] fa, a;
	logic [7:0] fdo, fq, d;
	wire logic [7:0] fdi;
	int fail_count, checks_done, cyc, seed, merr;
	assign fdi = foe_n ? fq : fdo;
	ffc_host ffc_host_i (.CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(pad), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
		.PREADY_OUT(pready), .PSLVERR_OUT(perr), .FL_ADDR_OUT(fa), .FL_DQ_OUT(fdo),
		.FL_DQ_OE_N_OUT(foe_n), .FL_DQ_IN(fdi), .FL_CE_N_OUT(ce_n), .FL_WE_N_OUT(we_n),
		.FL_OE_N_OUT(oe_n));
	ffc_flash_model ffc_flash_model_i (.addr_in(fa), .data_in(fdo), .data_oe_n_in(foe_n),
		.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .q_out(fq), .err_out(merr));
	always #20 clk = !clk;
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			close_out();
		end
	end
	function automatic logic [7:0] exp_st(input logic bad);
		return bad ? 8'h06 : 8'h02;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		pwr <= w;
		pad <= ad;
		pwd <= wd;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic run(input logic [2:0] op, input logic [16:0] ad, input logic [7:0] dt);
		apb(1'b1, `FFC_ADDR_OFF, {15'h0000, ad});
		apb(1'b1, `FFC_WDATA_OFF, {24'h000000, dt});
		apb(1'b1, `FFC_CTRL_OFF, {29'h00000000, op});
		do begin
			apb(1'b0, `FFC_STAT_OFF, 32'h00000000);
		end while (r[0] !== 1'b0);
		st = r;
	endtask
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		pad = 12'h000;
		pwd = 32'h00000000;
		fail_count = 0;
		checks_done = 0;
		cyc = 0;
		seed = 30542;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, `FFC_STAT_OFF, 32'h00000000);
		chk(r[7:0], 8'h00, "status after reset");
		apb(1'b0, 12'h010, 32'h00000000);
		chk({7'h00, e}, 8'h01, "unmapped access");
		run(3'h2, 17'h00000, 8'h00);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "chip erase");
		repeat (4) begin
			a = {1'b1, 16'($random(seed))};
			d = 8'($random(seed));
			run(3'h1, a, d);
			chk({4'h0, st[3:0]}, exp_st(1'b0), "program");
			run(3'h0, a, 8'h00);
			chk(st[15:8], d, "read back");
		end
		run(3'h3, a, 8'h00);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "sector erase");
		run(3'h0, a, 8'h00);
		chk(st[15:8], 8'hFF, "erased byte");
		run(3'h4, a, 8'h00);
		chk({4'h0, st[3:0]}, 8'h0A, "sector add after erase ended");
		run(3'h5, a, 8'h00);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "suspend with no erase running");
		chk(st[15:8], 8'hFF, "byte after stray suspend");
		d = 8'($random(seed)) & 8'h7F;
		run(3'h1, a, d);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "program erased byte");
		run(3'h1, a, ~d);
		chk({4'h0, st[3:0]}, exp_st(1'b1), "locked program");
		apb(1'b0, `FFC_CTRL_OFF, 32'h00000000);
		chk({5'h00, r[2:0]}, 8'h07, "abort after failure");
		run(3'h0, a, 8'h00);
		chk(st[15:8], d, "byte after abort");
		run(3'h6, a, 8'h00);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "resume with nothing suspended");
		run(3'h0, a, 8'h00);
		chk(st[15:8], d, "byte after stray resume");
		run(3'h7, a, 8'h00);
		chk({4'h0, st[3:0]}, exp_st(1'b0), "reset op");
		chk(8'(merr), 8'h00, "write strobes");
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		apb(1'b0, `FFC_STAT_OFF, 32'h00000000);
		chk(r[7:0], 8'h00, "status after second reset");
		close_out();
	end
endmodule

// >>> logic/ffc_host.sv
// APB-controlled host that sequences commands and status polls on a byte-wide flash.
`timescale 1ns/100ps
`include "ffc_map.svh"
module ffc_host import ffc_pkg::*; (
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	// APB slave.
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Flash pins.
	output logic [16:0] FL_ADDR_OUT,
	output logic [7:0] FL_DQ_OUT,
	output logic FL_DQ_OE_N_OUT,
	input wire logic [7:0] FL_DQ_IN,
	output logic FL_CE_N_OUT,
	output logic FL_WE_N_OUT,
	output logic FL_OE_N_OUT
);
	ffc_state_e state, next_state;
	ffc_op_e op, next_op;
	logic [16:0] addr, next_addr, fl_addr, next_fl_addr;
	logic [7:0] wdata, next_wdata, dq, next_dq, rd, next_rd, prev, next_prev;
	logic [7:0] dq_s1, dq_s2;
	logic [3:0] cnt, next_cnt;
	logic [2:0] step, next_step;
	logic busy, next_busy, done, next_done, fail, next_fail;
	logic rejected, next_rejected, have_prev, next_have_prev;
	logic fail_pend, next_fail_pend, post, next_post;
	logic ce_n, next_ce_n, we_n, next_we_n, oe_n, next_oe_n, dq_oe_n, next_dq_oe_n;
	logic last_eq, next_last_eq;
	logic apb_wr, go, bad_addr;

	// Address and data of write cycle k of an operation.
	function automatic logic [24:0] wr_cycle(input ffc_op_e o, input logic [2:0] k,
		input logic [16:0] a, input logic [7:0] d);
		logic [24:0] r;
		r = {a, `FFC_CMD_RESET};
		case (o)
			FFC_OP_PROG, FFC_OP_CHIP, FFC_OP_SECT: begin
				case (k)
					3'h0, 3'h3: r = {`FFC_UNLK1_ADDR, `FFC_UNLK1_DATA};
					3'h1, 3'h4: r = {`FFC_UNLK2_ADDR, `FFC_UNLK2_DATA};
					3'h2: r = {`FFC_CMD_ADDR, (o == FFC_OP_PROG) ? `FFC_CMD_PROG : `FFC_CMD_SETUP};
					default: r = {(o == FFC_OP_CHIP) ? `FFC_CMD_ADDR : a,
						(o == FFC_OP_CHIP) ? `FFC_CMD_CHIP : `FFC_CMD_SECT};
				endcase
				if (o == FFC_OP_PROG && k == 3'h3) begin
					r = {a, d};
				end
			end
			FFC_OP_ADD: r = {a, `FFC_CMD_SECT};
			FFC_OP_SUSP: r = {a, `FFC_CMD_SUSP};
			FFC_OP_RESUME: r = {a, `FFC_CMD_RESUME};
			default: r = {a, `FFC_CMD_RESET};
		endcase
		return r;
	endfunction

	// Number of write cycles of an operation.
	function automatic logic [2:0] wr_count(input ffc_op_e o);
		case (o)
			FFC_OP_PROG: return 3'h4;
			FFC_OP_CHIP, FFC_OP_SECT: return 3'h6;
			FFC_OP_READ: return 3'h0;
			default: return 3'h1;
		endcase
	endfunction

	assign apb_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign go = apb_wr && PADDR_IN == `FFC_CTRL_OFF && !busy;
	assign bad_addr = PADDR_IN[1:0] != 2'h0 || PADDR_IN > `FFC_STAT_OFF;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && bad_addr;
	always_comb begin
		PRDATA_OUT = 32'h0;
		case (PADDR_IN)
			`FFC_CTRL_OFF: PRDATA_OUT = {29'h0, op};
			`FFC_ADDR_OFF: PRDATA_OUT = {15'h0, addr};
			`FFC_WDATA_OFF: PRDATA_OUT = {24'h0, wdata};
			`FFC_STAT_OFF: PRDATA_OUT = {16'h0, rd, 4'h0, rejected, fail, done, busy};
			default: PRDATA_OUT = 32'h0;
		endcase
	end
	assign FL_ADDR_OUT = fl_addr;
	assign FL_DQ_OUT = dq;
	assign FL_DQ_OE_N_OUT = dq_oe_n;
	assign FL_CE_N_OUT = ce_n;
	assign FL_WE_N_OUT = we_n;
	assign FL_OE_N_OUT = oe_n;

	always_comb begin
		logic [24:0] cyc;
		logic settled;
		cyc = wr_cycle(op, step, addr, wdata);
		settled = 1'b0;
		next_state = state;
		next_op = op;
		next_addr = addr;
		next_wdata = wdata;
		next_fl_addr = fl_addr;
		next_dq = dq;
		next_rd = rd;
		next_prev = prev;
		next_cnt = cnt;
		next_step = step;
		next_busy = busy;
		next_done = done;
		next_fail = fail;
		next_rejected = rejected;
		next_have_prev = have_prev;
		next_fail_pend = fail_pend;
		next_post = post;
		next_ce_n = ce_n;
		next_we_n = we_n;
		next_oe_n = oe_n;
		next_dq_oe_n = dq_oe_n;
		next_last_eq = last_eq;
		if (apb_wr && PADDR_IN == `FFC_ADDR_OFF && !busy) begin
			next_addr = PWDATA_IN[16:0];
		end
		if (apb_wr && PADDR_IN == `FFC_WDATA_OFF && !busy) begin
			next_wdata = PWDATA_IN[7:0];
		end
		case (state)
			FFC_IDLE: begin
				if (go) begin
					next_op = ffc_op_e'(PWDATA_IN[2:0]);
					next_busy = 1'b1;
					next_done = 1'b0;
					next_fail = 1'b0;
					next_rejected = 1'b0;
					next_have_prev = 1'b0;
					next_fail_pend = 1'b0;
					next_post = 1'b0;
					next_step = 3'h0;
					// A sector load first reads, then writes, then reads the window bit.
					if (PWDATA_IN[2:0] == FFC_OP_READ || PWDATA_IN[2:0] == FFC_OP_ADD) begin
						next_state = FFC_RWAIT;
						next_ce_n = 1'b0;
						next_oe_n = 1'b0;
						next_fl_addr = next_addr;
						next_cnt = 4'(`FFC_RD_CYC);
					end else begin
						next_state = FFC_WSET;
					end
				end
			end
			FFC_WSET: begin
				// Output enable is raised before the strobe can fall.
				next_fl_addr = cyc[24:8];
				next_dq = cyc[7:0];
				next_dq_oe_n = 1'b0;
				next_oe_n = 1'b1;
				next_ce_n = 1'b0;
				next_state = FFC_WLOW;
				// One extra count gives a setup cycle before the strobe falls.
				next_cnt = 4'(`FFC_WE_LOW_CYC + 1);
			end
			FFC_WLOW: begin
				// Address and data were launched a cycle earlier, so the flash latches settled values.
				next_cnt = cnt - 4'h1;
				next_we_n = 1'b0;
				if (cnt == 4'h1) begin
					next_we_n = 1'b1;
					next_state = FFC_WHIGH;
				end
			end
			FFC_WHIGH: begin
				next_ce_n = 1'b1;
				next_dq_oe_n = 1'b1;
				next_step = step + 3'h1;
				// The whole sequence runs back to back so loads land inside the window.
				if (step + 3'h1 < wr_count(op)) begin
					next_state = FFC_WSET;
				end else if (fail_pend || op == FFC_OP_RESET) begin
					next_state = FFC_IDLE;
					next_busy = 1'b0;
					next_done = 1'b1;
				end else begin
					next_state = FFC_RWAIT;
					next_post = 1'b1;
					next_ce_n = 1'b0;
					next_oe_n = 1'b0;
					next_fl_addr = addr;
					next_cnt = 4'(`FFC_RD_CYC);
				end
			end
			FFC_RWAIT: begin
				next_cnt = cnt - 4'h1;
				if (cnt == 4'h1) begin
					next_rd = dq_s2;
					next_ce_n = 1'b1;
					next_oe_n = 1'b1;
					next_state = FFC_RCHK;
				end
			end
			FFC_RCHK: begin
				settled = have_prev && rd[`FFC_TOGGLE_BIT] == prev[`FFC_TOGGLE_BIT];
				next_prev = rd;
				next_have_prev = 1'b1;
				next_state = FFC_IDLE;
				next_busy = 1'b0;
				next_done = 1'b1;
				if (op == FFC_OP_READ) begin
					next_state = FFC_IDLE;
				end else if (op == FFC_OP_ADD && !post) begin
					next_state = FFC_WSET;
					next_busy = 1'b1;
					next_done = 1'b0;
				end else if (op == FFC_OP_ADD) begin
					next_rejected = rd[`FFC_WINDOW_BIT];
				end else if (settled && (op == FFC_OP_SUSP || op == FFC_OP_RESUME
					|| (op == FFC_OP_PROG && rd[`FFC_POLL_BIT] == wdata[`FFC_POLL_BIT])
					|| (op != FFC_OP_PROG && rd[`FFC_POLL_BIT]))) begin
					next_last_eq = 1'b1;
				end else if (have_prev && !settled && rd[`FFC_TIMEOUT_BIT]
					&& prev[`FFC_TIMEOUT_BIT]) begin
					// The read that sees completion returns array data, so one timeout bit
					// alone is not trusted. A locked algorithm only ends through the reset code.
					next_fail = 1'b1;
					next_fail_pend = 1'b1;
					next_op = FFC_OP_RESET;
					next_step = 3'h0;
					next_state = FFC_WSET;
					next_busy = 1'b1;
					next_done = 1'b0;
				end else begin
					next_last_eq = 1'b0;
					next_state = FFC_RWAIT;
					next_busy = 1'b1;
					next_done = 1'b0;
					next_ce_n = 1'b0;
					next_oe_n = 1'b0;
					next_cnt = 4'(`FFC_RD_CYC);
				end
			end
			default: next_state = FFC_IDLE;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		dq_s1 <= FL_DQ_IN;
		dq_s2 <= dq_s1;
		if (!RESETN_IN) begin
			state <= FFC_IDLE;
			op <= FFC_OP_READ;
			addr <= 17'h0;
			wdata <= 8'h0;
			fl_addr <= 17'h0;
			dq <= 8'h0;
			rd <= 8'h0;
			prev <= 8'h0;
			cnt <= 4'h0;
			step <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
			fail <= 1'b0;
			rejected <= 1'b0;
			have_prev <= 1'b0;
			fail_pend <= 1'b0;
			post <= 1'b0;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			dq_oe_n <= 1'b1;
			last_eq <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			addr <= next_addr;
			wdata <= next_wdata;
			fl_addr <= next_fl_addr;
			dq <= next_dq;
			rd <= next_rd;
			prev <= next_prev;
			cnt <= next_cnt;
			step <= next_step;
			busy <= next_busy;
			done <= next_done;
			fail <= next_fail;
			rejected <= next_rejected;
			have_prev <= next_have_prev;
			fail_pend <= next_fail_pend;
			post <= next_post;
			ce_n <= next_ce_n;
			we_n <= next_we_n;
			oe_n <= next_oe_n;
			dq_oe_n <= next_dq_oe_n;
			last_eq <= next_last_eq;
		end
	end

	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	sequence s_we_fall;
		$fell(we_n);
	endsequence
	sequence s_we_pulse;
		!we_n [*2] ##1 we_n;
	endsequence
	property p_inhibit;
		!we_n |-> !ce_n && oe_n && !dq_oe_n;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("write strobe without select");
	property p_hold;
		s_we_fall |-> ($stable(fl_addr) && $stable(dq)) [*2];
	endproperty
	a_hold: assert property (p_hold) else $error("address or data moved in pulse");
	property p_pulse;
		s_we_fall |-> s_we_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse length wrong");
	property p_prog_cmd;
		state == FFC_WLOW && op == FFC_OP_PROG && step == 3'h2 |-> dq == `FFC_CMD_PROG;
	endproperty
	a_prog_cmd: assert property (p_prog_cmd) else $error("third program write not A0");
	property p_prog_data;
		state == FFC_WLOW && op == FFC_OP_PROG && step == 3'h3 |-> dq == wdata && fl_addr == addr;
	endproperty
	a_prog_data: assert property (p_prog_data) else $error("program byte not sent");
	property p_sect_seq;
		state == FFC_WLOW && op == FFC_OP_SECT |-> (step != 3'h2 || dq == `FFC_CMD_SETUP)
			&& (step != 3'h5 || dq == `FFC_CMD_SECT);
	endproperty
	a_sect_seq: assert property (p_sect_seq) else $error("sector erase codes wrong");
	property p_done_ok;
		$rose(done) && !fail && op != FFC_OP_READ && op != FFC_OP_ADD && op != FFC_OP_RESET
			|-> last_eq;
	endproperty
	a_done_ok: assert property (p_done_ok) else $error("done without steady toggle");
	property p_fail_reset;
		state == FFC_WLOW && fail_pend |-> dq == `FFC_CMD_RESET;
	endproperty
	a_fail_reset: assert property (p_fail_reset) else $error("failure not reset");
	property p_fail_end;
		$rose(we_n) && fail_pend |-> ##[1:3] done && fail;
	endproperty
	a_fail_end: assert property (p_fail_end) else $error("reset did not end operation");
	property p_load_gap;
		$rose(we_n) && state == FFC_WHIGH && step + 3'h1 < wr_count(op) |-> ##[1:4] s_we_fall;
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("gap between writes too long");
	property p_reject;
		$rose(done) && op == FFC_OP_ADD |-> rejected == rd[`FFC_WINDOW_BIT];
	endproperty
	a_reject: assert property (p_reject) else $error("window check not reported");
endmodule

// >>> logic/ffc_map.svh
// Offsets, command codes and timing counts of the flash command host.
`ifndef FFC_MAP_SVH
`define FFC_MAP_SVH
`define FFC_CTRL_OFF 12'h000
`define FFC_ADDR_OFF 12'h004
`define FFC_WDATA_OFF 12'h008
`define FFC_STAT_OFF 12'h00C
`define FFC_UNLK1_ADDR 17'h05555
`define FFC_UNLK2_ADDR 17'h02AAA
`define FFC_CMD_ADDR 17'h05555
`define FFC_UNLK1_DATA 8'hAA
`define FFC_UNLK2_DATA 8'h55
`define FFC_CMD_PROG 8'hA0
`define FFC_CMD_SETUP 8'h80
`define FFC_CMD_CHIP 8'h10
`define FFC_CMD_SECT 8'h30
`define FFC_CMD_SUSP 8'hB0
`define FFC_CMD_RESUME 8'h30
`define FFC_CMD_RESET 8'hF0
`define FFC_POLL_BIT 7
`define FFC_TOGGLE_BIT 6
`define FFC_TIMEOUT_BIT 5
`define FFC_WINDOW_BIT 3
`define FFC_CLK_NS 40
`define FFC_WE_LOW_NS 80
`define FFC_WE_LOW_CYC ((`FFC_WE_LOW_NS + `FFC_CLK_NS - 1) / `FFC_CLK_NS)
`define FFC_ACC_NS 120
`define FFC_SYNC_CYC 2
`define FFC_RD_CYC (((`FFC_ACC_NS + `FFC_CLK_NS - 1) / `FFC_CLK_NS) + `FFC_SYNC_CYC)
`endif

// >>> logic/ffc_pkg.sv
// Types shared by the flash command host.
package ffc_pkg;
	typedef enum logic [2:0] {
		FFC_OP_READ = 3'h0,
		FFC_OP_PROG = 3'h1,
		FFC_OP_CHIP = 3'h2,
		FFC_OP_SECT = 3'h3,
		FFC_OP_ADD = 3'h4,
		FFC_OP_SUSP = 3'h5,
		FFC_OP_RESUME = 3'h6,
		FFC_OP_RESET = 3'h7
	} ffc_op_e;
	typedef enum logic [5:0] {
		FFC_IDLE = 6'h01,
		FFC_WSET = 6'h02,
		FFC_WLOW = 6'h04,
		FFC_WHIGH = 6'h08,
		FFC_RWAIT = 6'h10,
		FFC_RCHK = 6'h20
	} ffc_state_e;
endpackage
